// [shared/csg_pkg.sv]
/*
 contents: constants, register map and types of the shutter signal generator.
 assumes: included before every design file of the block.
*/
`default_nettype none
package csg_pkg;
   // field widths of counts and positions
   localparam int FIELD_W = 12;
   localparam int LINE_W = 12;
   localparam int PIX_W = 13;
   localparam int N_GATES = 4;
   // register byte offsets
   localparam logic [7:0] OFS_ROUTE = 8'h00;
   localparam logic [7:0] OFS_BIAS = 8'h04;
   localparam logic [7:0] OFS_TRIG = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_GCTL = 8'h10;
   localparam logic [1:0] GATE_PAGE = 2'h1;
   localparam logic [1:0] GSUB_ON = 2'h0;
   localparam logic [1:0] GSUB_OFF = 2'h1;
   localparam logic [1:0] GSUB_FD = 2'h2;
   // field positions
   localparam int ROUTE_SUB = 0;
   localparam int ROUTE_MECH = 4;
   localparam int ROUTE_FLASH = 8;
   localparam int ROUTE_TEST = 12;
   localparam int ROUTE_B0X = 16;
   localparam int ROUTE_B1X = 17;
   localparam int ROUTE_PAIR = 18;
   localparam int BIAS_MODE = 0;
   localparam int BIAS_HOLD = 1;
   localparam int BIAS_POL = 2;
   localparam int BIAS_LINE = 16;
   localparam int TRIG_ALL = 0;
   localparam int TRIG_B0 = 4;
   localparam int TRIG_B1 = 5;
   localparam int TRIG_EXP = 6;
   localparam int TRIG_RO = 7;
   localparam int POS_PX = 13;
   localparam int FD_OFF = 16;
   localparam int GCTL_MANON = 0;
   localparam int GCTL_POL = 1;
   localparam int GCTL_MANEN = 2;
   // writable bits of each register
   localparam logic [31:0] ROUTE_MASK = 32'h0007_7777;
   localparam logic [31:0] BIAS_MASK = 32'h0FFF_0007;
   localparam logic [31:0] GCTL_MASK = 32'h0000_7777;
   localparam logic [31:0] POS_MASK = 32'h03FF_EFFF;
   localparam logic [31:0] FD_MASK = 32'h0FFF_0FFF;
   localparam logic [31:0] RST_VAL = 32'h0000_0000;
   // select codes shared by all output routes
   localparam logic [2:0] SEL_BAD = 3'h6;
   // trigger sequencing of one exposure gate
   typedef enum logic [1:0] {
      CSG_IDLE = 2'b00,
      CSG_AUTO = 2'b01,
      CSG_SWAIT = 2'b10,
      CSG_SRUN = 2'b11
   } csg_arm_t;
endpackage : csg_pkg
`default_nettype wire

// [hw/csg_bias.sv]
/*
 contents: one substrate-bias generator with two start modes and hold.
 assumes: readout pulses and counts arrive on hclk from the timing generator.
*/
`timescale 1ns/1ps
`default_nettype none
module csg_bias
   import csg_pkg::*;
(
   input wire logic hclk, // pixel clock
   input wire logic hresetn, // async reset, low
   input wire logic arm, // trigger write pulse
   input wire logic mode, // start mode select
   input wire logic hold, // hold after readout
   input wire logic pol, // level when on
   input wire logic [LINE_W-1:0] on_line, // mode 0 start line
   input wire logic exp_zero, // in exposure field 0
   input wire logic [LINE_W-1:0] line_cnt, // current line
   input wire logic [PIX_W-1:0] pix_cnt, // current pixel
   input wire logic ro_start, // readout begins
   input wire logic ro_end, // readout finished
   output logic bias_on, // generator state
   output logic bias_lvl, // polarity applied
   output logic armed // waiting for start
);
   logic on_q, on_d; // bias active
   logic arm_q, arm_d; // armed, not yet on
   logic done_q, done_d; // readout over, held
   wire start0 = exp_zero && line_cnt == on_line && pix_cnt == '0;
   wire go = arm_q && (mode ? ro_start : start0);
   wire rel = on_q && !hold && (ro_end || done_q);

   // next state of the generator
   always_comb
   begin
      arm_d = (arm_q && !go) || arm;
      on_d = go || (on_q && !rel);
      done_d = on_q && !rel && (done_q || ro_end);
   end

   // state registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         on_q <= 1'b0;
         arm_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         on_q <= on_d;
         arm_q <= arm_d;
         done_q <= done_d;
      end
   end

   assign bias_on = on_q;
   assign bias_lvl = on_q ^ ~pol;
   assign armed = arm_q;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_mode_one_start: assert property (
      arm_q && mode && ro_start |=> on_q && !arm_q)
      else $error("bias missed readout start");
   chk_hold_stays: assert property (
      on_q && hold && !go ##1 hold |-> on_q)
      else $error("bias dropped while held");
   chk_ro_release: assert property (
      on_q && ro_end && !hold && !go |=> !on_q)
      else $error("bias not released at readout end");
endmodule : csg_bias
`default_nettype wire

// [hw/csg_gate.sv]
/*
 contents: one exposure gate with automatic, single and manual toggling.
 assumes: counts and field start pulse arrive on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module csg_gate
   import csg_pkg::*;
(
   input wire logic hclk, // pixel clock
   input wire logic hresetn, // async reset, low
   input wire logic arm, // trigger write pulse
   input wire logic use_auto, // exposure triggered or running
   input wire logic field_start, // field sync pulse
   input wire logic exp_active, // exposure running
   input wire logic [FIELD_W-1:0] exp_field, // exposure field count
   input wire logic [LINE_W-1:0] line_cnt, // current line
   input wire logic [PIX_W-1:0] pix_cnt, // current pixel
   input wire logic [31:0] on_pos, // on line and pixel
   input wire logic [31:0] off_pos, // off line and pixel
   input wire logic [31:0] fields, // on and off fields
   input wire logic man_en, // manual mode
   input wire logic man_on, // manual target
   input wire logic pol, // active polarity
   output logic gate_on, // gate state
   output logic gate_lvl, // polarity applied
   output logic armed // trigger pending
);
   csg_arm_t st_q, st_d; // trigger sequencer
   logic on_q, on_d; // gate state
   wire at_on = line_cnt == on_pos[LINE_W-1:0] && pix_cnt == on_pos[POS_PX+:PIX_W];
   wire at_off = line_cnt == off_pos[LINE_W-1:0] && pix_cnt == off_pos[POS_PX+:PIX_W];
   wire fd_on = exp_active && exp_field == fields[FIELD_W-1:0];
   wire fd_off = exp_active && exp_field == fields[FD_OFF+:FIELD_W];
   wire win_on = (st_q == CSG_AUTO && fd_on) || st_q == CSG_SRUN;
   wire win_off = (st_q == CSG_AUTO && fd_off) || st_q == CSG_SRUN;
   wire trig_on = win_on && at_on && !on_q;
   wire trig_off = win_off && at_off;
   wire tog_on = man_en ? (man_on && at_on) : trig_on;
   wire tog_off = man_en ? (!man_on && at_off) : trig_off;

   // sequencer next state
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         CSG_IDLE:
         begin
            if (arm)
               st_d = use_auto ? CSG_AUTO : CSG_SWAIT;
         end
         CSG_AUTO:
         begin
            if (!man_en && trig_off)
               st_d = CSG_IDLE;
         end
         CSG_SWAIT:
         begin
            if (field_start)
               st_d = CSG_SRUN;
         end
         CSG_SRUN:
         begin
            if (field_start || (!man_en && trig_off))
               st_d = CSG_IDLE;
         end
         default:
            st_d = CSG_IDLE;
      endcase
   end

   assign on_d = tog_on ? 1'b1 : (tog_off ? 1'b0 : on_q);

   // state registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q <= CSG_IDLE;
         on_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         on_q <= on_d;
      end
   end

   assign gate_on = on_q;
   assign gate_lvl = on_q ^ ~pol;
   assign armed = st_q != CSG_IDLE;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_manual_on: assert property (
      man_en && man_on && at_on |=> on_q)
      else $error("manual on not applied");
   chk_manual_kept: assert property (
      on_q && !man_en && st_q == CSG_IDLE |=> on_q)
      else $error("gate fell without a toggle");
   chk_auto_off: assert property (
      st_q == CSG_AUTO && !man_en && fd_off && at_off |=> !on_q && st_q == CSG_IDLE)
      else $error("automatic off missed");
endmodule : csg_gate
`default_nettype wire

// [hw/csg_top.sv]
/*
 contents: shutter signal generator top, AHB-Lite registers, gates,
 bias generators, combiners and the output pin routing.
 assumes: counts, field start and readout pulses come from the timing
 generator on hclk; one AHB-Lite master drives the slave port.
*/
// Notes on behaviour
// - mode 0: bias on in exposure field 0
// - bias start line programmable, 0 to 4095
// - bias stays on until readout ends
// - mode 1: bias on at readout start
// - hold bit keeps bias on after readout
// - two bias generators, routable to pins
// - bias combiner: plain or XOR gate 0
// - pair combiner: gate 0 XOR gate 1/2
// - 3-bit pin selects, code 6 invalid
// - test output uses same select table
// - polarity sets bias level when on
// - automatic gates fire with exposure only
// - gate fields counted against exposure counter
// - single trigger acts in next field only
// - exposure trigger forces automatic mode
// - manual mode applies on or off position
// - manual mode ignores field values
// - manual works regardless of exposure state
// - gate stays on after manual disabled
// - trigger on an on gate: off only
// - each gate has its own polarity
// - trigger bits arm gates, bias, operations
// - 12-bit field/line, 13-bit pixel positions
// - manual enable and on/off bits per gate
`timescale 1ns/1ps
`default_nettype none
module csg_top
   import csg_pkg::*;
(
   input wire logic hclk, // pixel clock
   input wire logic hresetn, // async reset, low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write access
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire logic field_start, // field sync pulse
   input wire logic exp_active, // exposure running
   input wire logic [FIELD_W-1:0] exp_field, // exposure field count
   input wire logic [LINE_W-1:0] line_cnt, // current line
   input wire logic [PIX_W-1:0] pix_cnt, // current pixel
   input wire logic ro_start, // readout begins
   input wire logic ro_end, // readout finished
   output logic exposure_start_req, // exposure trigger pulse
   output logic readout_start_req, // readout trigger pulse
   output logic substrate_bias_pin, // bias pin
   output logic mech_gate_pin, // mechanical shutter pin
   output logic flash_pin, // flash pin
   output logic test_output // test pin
);
   // bus phase tracking
   logic wr_q; // write data phase
   logic rd_q; // read data phase
   logic rd_done_q; // read data loaded
   logic [7:0] addr_q; // latched offset
   logic map_q; // address in the 256-byte window
   logic [31:0] hrdata_q; // read data register
   // software registers
   logic [31:0] route_q; // pin selects and combiners
   logic [31:0] bias_q; // bias mode, hold, polarity, line
   logic [31:0] gctl_q; // gate manual and polarity bits
   logic [31:0] gon_q [N_GATES]; // gate on positions
   logic [31:0] goff_q [N_GATES]; // gate off positions
   logic [31:0] gfd_q [N_GATES]; // gate field values
   // trigger pulses
   logic exp_req_q; // exposure request
   logic ro_req_q; // readout request
   // pin registers
   logic sub_q; // bias pin level
   logic mech_q; // mechanical pin level
   logic flash_q; // flash pin level
   logic test_q; // test pin level
   // block state
   logic [N_GATES-1:0] g_on; // gate states
   logic [N_GATES-1:0] g_lvl; // gate levels
   logic [N_GATES-1:0] g_armed; // gates armed
   logic [1:0] b_on; // bias states
   logic [1:0] b_lvl; // bias levels
   logic [1:0] b_armed; // bias armed

   // address phase accepted
   wire take = hsel && htrans[1] && hready;
   wire rd_load = rd_q && !rd_done_q;
   // register decode in the write data phase
   wire we = wr_q && map_q;
   wire gpage = addr_q[7:6] == GATE_PAGE;
   wire [1:0] gidx = addr_q[5:4];
   wire [1:0] gsub = addr_q[3:2];
   wire we_route = we && addr_q == OFS_ROUTE;
   wire we_bias = we && addr_q == OFS_BIAS;
   wire we_trig = we && addr_q == OFS_TRIG;
   wire we_gctl = we && addr_q == OFS_GCTL;
   wire we_gon = we && gpage && gsub == GSUB_ON && addr_q[1:0] == 2'h0;
   wire we_goff = we && gpage && gsub == GSUB_OFF && addr_q[1:0] == 2'h0;
   wire we_gfd = we && gpage && gsub == GSUB_FD && addr_q[1:0] == 2'h0;

   // bus phase registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rd_done_q <= 1'b0;
         addr_q <= 8'h00;
         map_q <= 1'b0;
      end
      else
      begin
         wr_q <= take && hwrite;
         rd_q <= (take && !hwrite) || (rd_q && !rd_done_q);
         rd_done_q <= rd_load;
         if (take)
         begin
            addr_q <= haddr[7:0];
            map_q <= haddr[31:8] == 24'h000000;
         end
      end
   end

   // read selection, unmapped offsets read zero
   wire [31:0] stat_w = {16'h0000, b_armed, g_armed,
      test_q, flash_q, mech_q, sub_q, b_on, g_on};
   wire [31:0] gate_rd = gsub == GSUB_ON ? gon_q[gidx] :
      gsub == GSUB_OFF ? goff_q[gidx] :
      gsub == GSUB_FD ? gfd_q[gidx] : 32'h0000_0000;
   wire [31:0] rd_mux = !map_q ? 32'h0000_0000 :
      addr_q == OFS_ROUTE ? route_q :
      addr_q == OFS_BIAS ? bias_q :
      addr_q == OFS_TRIG ? {26'h0, b_armed, g_armed} :
      addr_q == OFS_STAT ? stat_w :
      addr_q == OFS_GCTL ? gctl_q :
      (gpage && addr_q[1:0] == 2'h0) ? gate_rd : 32'h0000_0000;

   // read data register, loaded in the wait cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_q <= 32'h0000_0000;
      else if (rd_load)
         hrdata_q <= rd_mux;
   end

   assign hrdata = hrdata_q;
   assign hreadyout = !rd_load;
   assign hresp = 1'b0;

   // control registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         route_q <= RST_VAL;
         bias_q <= RST_VAL;
         gctl_q <= RST_VAL;
      end
      else
      begin
         if (we_route)
            route_q <= hwdata & ROUTE_MASK;
         if (we_bias)
            bias_q <= hwdata & BIAS_MASK;
         if (we_gctl)
            gctl_q <= hwdata & GCTL_MASK;
      end
   end

   // gate position registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < N_GATES; i++)
         begin
            gon_q[i] <= RST_VAL;
            goff_q[i] <= RST_VAL;
            gfd_q[i] <= RST_VAL;
         end
      end
      else
      begin
         if (we_gon)
            gon_q[gidx] <= hwdata & POS_MASK;
         if (we_goff)
            goff_q[gidx] <= hwdata & POS_MASK;
         if (we_gfd)
            gfd_q[gidx] <= hwdata & FD_MASK;
      end
   end

   wire [N_GATES-1:0] g_arm = {N_GATES{we_trig}} &
      ({N_GATES{hwdata[TRIG_ALL]}} | {hwdata[3:1], 1'b0});
   wire [1:0] b_arm = {2{we_trig}} & hwdata[TRIG_B1:TRIG_B0];
   wire use_auto = (we_trig && hwdata[TRIG_EXP]) || exp_active;

   // operation request pulses
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         exp_req_q <= 1'b0;
         ro_req_q <= 1'b0;
      end
      else
      begin
         exp_req_q <= we_trig && hwdata[TRIG_EXP];
         ro_req_q <= we_trig && hwdata[TRIG_RO];
      end
   end

   assign exposure_start_req = exp_req_q;
   assign readout_start_req = ro_req_q;

   genvar g;
   generate
      for (g = 0; g < N_GATES; g++)
      begin : gl
         csg_gate u_gate (
            .hclk(hclk),
            .hresetn(hresetn),
            .arm(g_arm[g]),
            .use_auto(use_auto),
            .field_start(field_start),
            .exp_active(exp_active),
            .exp_field(exp_field),
            .line_cnt(line_cnt),
            .pix_cnt(pix_cnt),
            .on_pos(gon_q[g]),
            .off_pos(goff_q[g]),
            .fields(gfd_q[g]),
            .man_en(gctl_q[4*g+GCTL_MANEN]),
            .man_on(gctl_q[4*g+GCTL_MANON]),
            .pol(gctl_q[4*g+GCTL_POL]),
            .gate_on(g_on[g]),
            .gate_lvl(g_lvl[g]),
            .armed(g_armed[g])
         );
      end
   endgenerate

   wire exp_zero = exp_active && exp_field == '0;

   generate
      for (g = 0; g < 2; g++)
      begin : bl
         csg_bias u_bias (
            .hclk(hclk),
            .hresetn(hresetn),
            .arm(b_arm[g]),
            .mode(bias_q[BIAS_MODE]),
            .hold(bias_q[BIAS_HOLD]),
            .pol(bias_q[BIAS_POL]),
            .on_line(bias_q[BIAS_LINE+:LINE_W]),
            .exp_zero(exp_zero),
            .line_cnt(line_cnt),
            .pix_cnt(pix_cnt),
            .ro_start(ro_start),
            .ro_end(ro_end),
            .bias_on(b_on[g]),
            .bias_lvl(b_lvl[g]),
            .armed(b_armed[g])
         );
      end
   endgenerate

   wire bias0_mix = route_q[ROUTE_B0X] ? g_lvl[0] ^ b_lvl[0] : b_lvl[0];
   wire bias1_mix = route_q[ROUTE_B1X] ? g_lvl[0] ^ b_lvl[1] : b_lvl[1];
   wire pair_mix = g_lvl[0] ^ (route_q[ROUTE_PAIR] ? g_lvl[2] : g_lvl[1]);
   // select table, code 6 drives low
   wire [7:0] src = {pair_mix, 1'b0, bias1_mix, bias0_mix, g_lvl};
   wire [2:0] sub_sel = route_q[ROUTE_SUB+:3];
   wire [2:0] mech_sel = route_q[ROUTE_MECH+:3];
   wire [2:0] flash_sel = route_q[ROUTE_FLASH+:3];
   wire [2:0] test_sel = route_q[ROUTE_TEST+:3];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sub_q <= 1'b0;
         mech_q <= 1'b0;
         flash_q <= 1'b0;
         test_q <= 1'b0;
      end
      else
      begin
         sub_q <= src[sub_sel];
         mech_q <= src[mech_sel];
         flash_q <= src[flash_sel];
         test_q <= src[test_sel];
      end
   end

   assign substrate_bias_pin = sub_q;
   assign mech_gate_pin = mech_q;
   assign flash_pin = flash_q;
   assign test_output = test_q;

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_read_take;
      take && !hwrite;
   endsequence
   sequence s_read_data;
      !hreadyout ##1 hreadyout;
   endsequence

   chk_read_wait: assert property (
      s_read_take |=> s_read_data)
      else $error("read not answered after one wait");
   chk_write_nowait: assert property (
      take && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_pin_route: assert property (
      sub_sel != SEL_BAD |=> sub_q == $past(src[sub_sel]))
      else $error("bias pin not following its select");
   chk_code_six: assert property (
      mech_sel == SEL_BAD |=> !mech_q)
      else $error("invalid select drove the pin");
   chk_test_route: assert property (
      test_sel == 3'h7 |=> test_q == $past(g_lvl[0] ^ (route_q[ROUTE_PAIR] ? g_lvl[2] : g_lvl[1])))
      else $error("test output not pair combiner");
   chk_bias_xor: assert property (
      flash_sel == 3'h4 && route_q[ROUTE_B0X] |=> flash_q == $past(g_lvl[0] ^ b_lvl[0]))
      else $error("bias combiner wrong");
   chk_trig_arm: assert property (
      we_trig && hwdata[TRIG_ALL] |=> &g_armed)
      else $error("gates not armed");
   chk_exp_pulse: assert property (
      we_trig && hwdata[TRIG_EXP] |=> exposure_start_req ##1 !exposure_start_req)
      else $error("exposure request not one pulse");
endmodule : csg_top
`default_nettype wire

// [dv/csg_tgen_model.sv]
/*
 holds: timing source model, giving counts, field sync and exposure fields.
 assumes: shares hclk with the shutter block; 16 pixels, 8 lines a field.
*/
`timescale 1ns/1ps
`default_nettype none
module csg_tgen_model
   import csg_pkg::*;
#(
   parameter int PIX_N = 16,
   parameter int LINE_N = 8
)
(
   input wire logic hclk, // pixel clock
   input wire logic hresetn, // async reset, low
   input wire logic exp_active, // exposure running
   output logic field_start, // one-cycle field sync
   output logic [FIELD_W-1:0] exp_field, // exposure field count
   output logic [LINE_W-1:0] line_cnt, // current line
   output logic [PIX_W-1:0] pix_cnt // current pixel
);
   wire logic last_pix = (pix_cnt == PIX_W'(PIX_N - 1)); // end of line
   assign field_start = (line_cnt == '0) && (pix_cnt == '0);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pix_cnt <= '0;
         line_cnt <= '0;
         exp_field <= '0;
      end
      else
      begin
         pix_cnt <= last_pix ? '0 : pix_cnt + 1'b1;
         if (last_pix)
            line_cnt <= (line_cnt == LINE_W'(LINE_N - 1)) ? '0 : line_cnt + 1'b1;
         if (field_start)
            exp_field <= exp_active ? exp_field + 1'b1 : '0;
      end
   end
endmodule : csg_tgen_model
`default_nettype wire

// [dv/ccd_shutter_signal_gen_tb_top.sv]
/*
 holds: self-checking bench for the shutter signal generator.
 assumes: one AHB-Lite master; the timing model supplies counts.
*/
`timescale 1ns/1ps
`default_nettype none
module ccd_shutter_signal_gen_tb_top
   import csg_pkg::*;
;
   logic hclk = 1'b0; // bus and pixel clock
   logic hresetn = 1'b0; // reset, low
   logic hsel = 1'b0; // slave select
   logic hwrite = 1'b0; // write access
   logic [1:0] htrans = 2'h0; // transfer type
   logic [31:0] haddr = 32'h0; // byte address
   logic [31:0] hwdata = 32'h0; // write data
   logic exp_active = 1'b0; // exposure running
   logic ro_start = 1'b0; // readout begins
   logic ro_end = 1'b0; // readout ends
   logic [31:0] hrdata, q; // read data, last read
   logic hreadyout, hresp, field_start, exp_req, ro_req; // bus and pulses
   logic [FIELD_W-1:0] exp_field; // exposure field
   logic [LINE_W-1:0] line_cnt; // line
   logic [PIX_W-1:0] pix_cnt; // pixel
   logic [3:0] pins; // sub, mech, flash, test
   int failures = 0, n_checks = 0, cyc = 0, n_exp = 0, n_ro = 0;
   always #5 hclk = ~hclk;
   csg_tgen_model u_csg_tgen_model (.hclk(hclk), .hresetn(hresetn), .exp_active(exp_active),
      .field_start(field_start), .exp_field(exp_field), .line_cnt(line_cnt), .pix_cnt(pix_cnt));
   csg_top u_csg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .field_start(field_start), .exp_active(exp_active),
      .exp_field(exp_field), .line_cnt(line_cnt), .pix_cnt(pix_cnt), .ro_start(ro_start),
      .ro_end(ro_end), .exposure_start_req(exp_req), .readout_start_req(ro_req),
      .substrate_bias_pin(pins[3]), .mech_gate_pin(pins[2]), .flash_pin(pins[1]), .test_output(pins[0]));
   // count request pulses where settled
   always @(negedge hclk)
   begin
      n_exp += (exp_req === 1'b1);
      n_ro += (ro_req === 1'b1);
   end
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch t=%0t exp %h got %h", $time, e, g);
      end
   endtask : chk
   // one single AHB-Lite word transfer
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(posedge hclk);
   endtask : xf
   task automatic st(input int b, input logic e);
      xf(1'b0, OFS_STAT, 32'h0);
      chk({31'h0, e}, {31'h0, q[b]});
   endtask : st
   task automatic pulse(input logic s);
      @(posedge hclk);
      ro_start <= s;
      ro_end <= !s;
      @(posedge hclk);
      ro_start <= 1'b0;
      ro_end <= 1'b0;
   endtask : pulse
   task automatic t_route();
      logic [7:0] hi = 8'h85; // codes 0, 2 and 7 high, code 6 low
      xf(1'b0, OFS_ROUTE, 32'h0);
      chk(RST_VAL, q); // reset value
      xf(1'b0, 8'hFC, 32'h0);
      chk(32'h0, q); // unmapped
      chk(32'h0, {31'h0, hresp}); // okay response
      // gates 1 and 3 active high, gates 0 and 2 active low
      xf(1'b1, OFS_GCTL, 32'h0000_2020);
      xf(1'b1, OFS_BIAS, 32'h0000_0004);
      for (int c = 0; c < 8; c++)
      begin
         xf(1'b1, OFS_ROUTE, {16'h0, 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)});
         repeat (3) @(negedge hclk);
         chk({28'h0, {4{hi[c]}}}, {28'h0, pins});
      end
      xf(1'b1, OFS_ROUTE, 32'h0001_4444);
      repeat (3) @(negedge hclk);
      chk(32'hF, {28'h0, pins});
      // pair select 1 and bias b combiner: sub and mech low, flash and test high
      xf(1'b1, OFS_ROUTE, 32'h0006_5577);
      repeat (3) @(negedge hclk);
      chk(32'h3, {28'h0, pins});
      $display("done route");
   endtask : t_route
   task automatic t_manual();
      xf(1'b1, 8'h50, 32'h0000_A003);
      xf(1'b1, 8'h54, 32'h0000_4006);
      xf(1'b1, 8'h58, 32'h0FFF_0FFF);
      xf(1'b1, OFS_GCTL, 32'h0000_2270);
      repeat (140) @(posedge hclk);
      st(1, 1'b1);
      xf(1'b1, OFS_GCTL, 32'h0000_2220);
      repeat (140) @(posedge hclk);
      st(1, 1'b1);
      xf(1'b1, OFS_TRIG, 32'h0000_0002);
      repeat (300) @(posedge hclk);
      st(1, 1'b0);
      $display("done manual");
   endtask : t_manual
   task automatic t_auto();
      xf(1'b1, 8'h60, 32'h0000_0002);
      xf(1'b1, 8'h64, 32'h0000_0004);
      xf(1'b1, 8'h68, 32'h0002_0001);
      xf(1'b1, OFS_BIAS, 32'h0001_0004);
      xf(1'b1, OFS_TRIG, 32'h0000_0054);
      @(posedge hclk iff field_start === 1'b1);
      exp_active <= 1'b1;
      repeat (100) @(posedge hclk);
      st(4, 1'b1);
      st(2, 1'b0);
      repeat (100) @(posedge hclk);
      st(2, 1'b1);
      repeat (128) @(posedge hclk);
      st(2, 1'b0);
      chk(32'd1, n_exp);
      exp_active <= 1'b0;
      pulse(1'b0);
      st(4, 1'b0);
      $display("done auto");
   endtask : t_auto
   task automatic t_hold();
      xf(1'b1, OFS_BIAS, 32'h0000_0007);
      xf(1'b1, OFS_TRIG, 32'h0000_00A0);
      repeat (200) @(posedge hclk);
      st(5, 1'b0);
      pulse(1'b1);
      st(5, 1'b1);
      pulse(1'b0);
      st(5, 1'b1);
      xf(1'b1, OFS_BIAS, 32'h0000_0005);
      st(5, 1'b0);
      chk(32'd1, n_ro);
      // bit 0 arms all four gates, bias generators stay idle
      xf(1'b1, OFS_TRIG, 32'h0000_0001);
      xf(1'b0, OFS_TRIG, 32'h0);
      chk(32'h0000_000F, q);
      $display("done hold");
   endtask : t_hold
   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // hang guard
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         finish_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_route();
      t_manual();
      t_auto();
      t_hold();
      finish_test();
   end
endmodule : ccd_shutter_signal_gen_tb_top
`default_nettype wire
